// ---- core/pcpom_pkg.sv ----
// package for the port c upper pin override mux
// assumes a single core clock domain and a plain register port
package pcpom_pkg;

  // ---------------------------------------------------------------
  // register map (indices on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [1:0] PCPOM_ADDR_PIN_LEVEL = 2'h0;
  localparam logic [1:0] PCPOM_ADDR_LATCH     = 2'h1;
  localparam logic [1:0] PCPOM_ADDR_DIRECTION = 2'h2;
  localparam logic [1:0] PCPOM_ADDR_PERIPH    = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PCPOM_DIR_RESET    = 8'hff;
  localparam logic [7:0] PCPOM_LATCH_RESET  = 8'h00;
  localparam logic [7:0] PCPOM_PERIPH_RESET = 8'h00;
  localparam logic [7:0] PCPOM_ZERO         = 8'h00;

  // ---------------------------------------------------------------
  // peripheral enable register fields
  // ---------------------------------------------------------------
  localparam int PCPOM_EN_I2C    = 0;
  localparam int PCPOM_EN_SPI    = 1;
  localparam int PCPOM_EN_ASYNC  = 2;
  localparam int PCPOM_EN_SMAST  = 3;
  localparam int PCPOM_EN_SSLV   = 4;
  localparam int PCPOM_EN_SYNTX  = 5;
  localparam int PCPOM_EN_SMBUS  = 6;

  // ---------------------------------------------------------------
  // pin positions
  // ---------------------------------------------------------------
  localparam int PCPOM_BIT_ONE   = 1;
  localparam int PCPOM_BIT_THREE = 3;
  localparam int PCPOM_BIT_FOUR  = 4;
  localparam int PCPOM_BIT_FIVE  = 5;
  localparam int PCPOM_BIT_SIX   = 6;
  localparam int PCPOM_BIT_SEVEN = 7;

  // peripheral outputs toward the pins
  typedef struct packed {
    logic i2c_clk_out;
    logic i2c_clk_oe;
    logic i2c_data_out;
    logic i2c_data_oe;
    logic spi_data_out;
    logic capture_out;
    logic capture_oe;
    logic xcvr_tx_data;
    logic xcvr_sync_clk_out;
    logic xcvr_sync_data_out;
  } pcpom_periph_t;

  // pin levels and the smbus buffer setting delivered to peripherals
  typedef struct packed {
    logic i2c_clk_in;
    logic i2c_data_in;
    logic spi_data_in;
    logic capture_in;
    logic xcvr_rx_data;
    logic xcvr_sync_clk_in;
    logic xcvr_sync_data_in;
    logic smbus_levels;
  } pcpom_feed_t;

endpackage

// ---- core/pcpom_mux.sv ----
// port c pin override mux: latch, direction, sampling and peripheral
// takeover of pins; assumes pins synchronous to clock_i and a plain
// register port with read data one cycle after the read strobe
//
// Summary of operation
// RQ1: direction 0 drives latch bit; direction 1 samples pin into port.
// RQ2: latch is read/write; reading it returns latch, not pin level.
// RQ3: i2c clock output overrides latch on bit three, direction 0.
// RQ4: bit three feeds i2c clock input; buffer type from smbus setting.
// RQ5: bit four feeds spi data input when direction is 1.
// RQ6: i2c data output drives bit four over port data.
// RQ7: bit four feeds i2c data input, buffer per module configuration.
// RQ8: spi data output drives bit five instead of latch.
// RQ9: async transmit drives bit six over port data.
// RQ10: sync master clock drives bit six over port data.
// RQ11: sync slave takes external clock from bit six.
// RQ12: async receive takes data from bit seven.
// RQ13: sync transmit drives bit seven over port data.
// RQ14: sync receive takes data from bit seven.
// RQ15: peripheral overrides ignore direction bit where marked don't-care.
// RQ16: capture pin on bit one when select set, else port b bit three.
// RQ17: direction 1 tri-states driver; 0 drives latch contents.
// RQ18: after reset every pin is an input.
// RQ19: direction reads return stored bits despite overrides.
// RQ20: port reads return sampled pin levels however driven.
// RQ21: mux picks enable and data from claiming peripheral, else latch.
`timescale 1ns/1ps

module pcpom_mux (
  input  wire logic                    clock_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [1:0]              addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [7:0]              rdata_o,
  input  wire logic                    capture_unit_pin_select_i,
  input  wire pcpom_pkg::pcpom_periph_t periph_i,
  output pcpom_pkg::pcpom_feed_t       feed_o,
  input  wire logic [7:0]              pin_i,
  output logic      [7:0]              pin_o,
  output logic      [7:0]              pin_oe_o,
  input  wire logic                    port_b_bit_three_i,
  output logic                         port_b_bit_three_o,
  output logic                         port_b_bit_three_oe_o
);
  import pcpom_pkg::*;

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0]    latch_reg,  latch_next;
  logic [7:0]    dir_reg,    dir_next;
  logic [7:0]    periph_reg, periph_next;
  logic [7:0]    sample_reg, sample_next;
  logic [7:0]    rdata_reg,  rdata_next;
  logic [7:0]    pin_reg,    pin_next;
  logic [7:0]    oe_reg,     oe_next;
  logic          pb3_reg,    pb3_next;
  logic          pb3_oe_reg, pb3_oe_next;
  pcpom_feed_t   feed_reg,   feed_next;

  // one pin: peripheral claim wins, else direction and latch
  function automatic logic [1:0] pick(input logic claim,
                                      input logic pdata,
                                      input logic dir,
                                      input logic lat);
    if (claim) begin
      pick = {1'b1, pdata};                 // [RQ21] [RQ15]
    end else begin
      pick = {~dir, lat};                   // [RQ1] [RQ17]
    end
  endfunction

  // -----------------------------------------------------------------
  // register file
  // -----------------------------------------------------------------
  always_comb begin
    latch_next  = latch_reg;
    dir_next    = dir_reg;
    periph_next = periph_reg;
    rdata_next  = rdata_reg;
    sample_next = pin_i;                    // [RQ20]
    if (wr_i) begin
      case (addr_i)
        PCPOM_ADDR_PIN_LEVEL: latch_next  = wdata_i;  // writes go to latch
        PCPOM_ADDR_LATCH:     latch_next  = wdata_i;  // [RQ2]
        PCPOM_ADDR_DIRECTION: dir_next    = wdata_i;
        PCPOM_ADDR_PERIPH:    periph_next = wdata_i;
        default:              latch_next  = latch_reg;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        PCPOM_ADDR_PIN_LEVEL: rdata_next = sample_reg;  // [RQ1] [RQ20]
        PCPOM_ADDR_LATCH:     rdata_next = latch_reg;   // [RQ2]
        PCPOM_ADDR_DIRECTION: rdata_next = dir_reg;     // [RQ19]
        PCPOM_ADDR_PERIPH:    rdata_next = periph_reg;
        default:              rdata_next = PCPOM_ZERO;
      endcase
    end else begin
      rdata_next = PCPOM_ZERO;              // data stands one cycle only
    end
  end

  // -----------------------------------------------------------------
  // override mux
  // -----------------------------------------------------------------
  always_comb begin
    logic [1:0] r;
    logic       cap_here;
    logic       sync_mode;
    r         = 2'h0;
    sync_mode = periph_reg[PCPOM_EN_SMAST] | periph_reg[PCPOM_EN_SSLV];
    cap_here  = capture_unit_pin_select_i;  // [RQ16]
    for (int i = 0; i < 8; i++) begin
      r = pick(1'b0, 1'b0, dir_reg[i], latch_reg[i]);
      pin_next[i] = r[0];
      oe_next[i]  = r[1];
    end
    // bit one: capture unit output when placed here
    r = pick(cap_here & periph_i.capture_oe, periph_i.capture_out,
             dir_reg[PCPOM_BIT_ONE], latch_reg[PCPOM_BIT_ONE]);
    pin_next[PCPOM_BIT_ONE] = r[0];
    oe_next[PCPOM_BIT_ONE]  = r[1];
    // bit three: i2c clock, i2c_clk_out driven high or low when i2c is enabled and i2c_clk_oe is set
    r = pick(periph_reg[PCPOM_EN_I2C] & periph_i.i2c_clk_oe,
             periph_i.i2c_clk_out,
             dir_reg[PCPOM_BIT_THREE], latch_reg[PCPOM_BIT_THREE]); // [RQ3]
    pin_next[PCPOM_BIT_THREE] = r[0];
    oe_next[PCPOM_BIT_THREE]  = r[1];
    // bit four: i2c data output over port data
    r = pick(periph_reg[PCPOM_EN_I2C] & periph_i.i2c_data_oe,
             periph_i.i2c_data_out,
             dir_reg[PCPOM_BIT_FOUR], latch_reg[PCPOM_BIT_FOUR]); // [RQ6]
    pin_next[PCPOM_BIT_FOUR] = r[0];
    oe_next[PCPOM_BIT_FOUR]  = r[1];
    // bit five: spi data out replaces latch, needs direction 0
    r = pick(periph_reg[PCPOM_EN_SPI] & ~dir_reg[PCPOM_BIT_FIVE],
             periph_i.spi_data_out,
             dir_reg[PCPOM_BIT_FIVE], latch_reg[PCPOM_BIT_FIVE]); // [RQ8]
    pin_next[PCPOM_BIT_FIVE] = r[0];
    oe_next[PCPOM_BIT_FIVE]  = r[1];
    // bit six: transmit data or master clock; slave leaves it input
    if (periph_reg[PCPOM_EN_ASYNC]) begin
      r = pick(1'b1, periph_i.xcvr_tx_data, 1'b1, 1'b0);      // [RQ9]
    end else if (periph_reg[PCPOM_EN_SMAST]) begin
      r = pick(1'b1, periph_i.xcvr_sync_clk_out, 1'b1, 1'b0); // [RQ10]
    end else if (periph_reg[PCPOM_EN_SSLV]) begin
      r = 2'h0;                                              // [RQ11]
    end else begin
      r = pick(1'b0, 1'b0, dir_reg[PCPOM_BIT_SIX],
               latch_reg[PCPOM_BIT_SIX]);
    end
    pin_next[PCPOM_BIT_SIX] = r[0];
    oe_next[PCPOM_BIT_SIX]  = r[1];
    // bit seven: sync transmit drives; receive leaves it to direction
    r = pick(sync_mode & periph_reg[PCPOM_EN_SYNTX],
             periph_i.xcvr_sync_data_out,
             dir_reg[PCPOM_BIT_SEVEN], latch_reg[PCPOM_BIT_SEVEN]); // [RQ13]
    pin_next[PCPOM_BIT_SEVEN] = r[0];
    oe_next[PCPOM_BIT_SEVEN]  = r[1];
    // alternate capture placement on port b bit three
    pb3_next    = periph_i.capture_out;                     // [RQ16]
    pb3_oe_next = ~cap_here & periph_i.capture_oe;
    // input feeds; smbus flag selects the buffer thresholds
    feed_next.i2c_clk_in        = pin_i[PCPOM_BIT_THREE];   // [RQ4]
    feed_next.i2c_data_in       = pin_i[PCPOM_BIT_FOUR];    // [RQ7]
    feed_next.spi_data_in       = pin_i[PCPOM_BIT_FOUR];    // [RQ5]
    feed_next.capture_in        = cap_here ? pin_i[PCPOM_BIT_ONE]
                                           : port_b_bit_three_i;
    feed_next.xcvr_rx_data      = pin_i[PCPOM_BIT_SEVEN];   // [RQ12]
    feed_next.xcvr_sync_clk_in  = pin_i[PCPOM_BIT_SIX];     // [RQ11]
    feed_next.xcvr_sync_data_in = pin_i[PCPOM_BIT_SEVEN];   // [RQ14]
    feed_next.smbus_levels      = periph_reg[PCPOM_EN_SMBUS]; // [RQ4] [RQ7]
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_reg  <= PCPOM_LATCH_RESET;
      dir_reg    <= PCPOM_DIR_RESET;        // [RQ18]
      periph_reg <= PCPOM_PERIPH_RESET;
      sample_reg <= PCPOM_ZERO;
      rdata_reg  <= PCPOM_ZERO;
      pin_reg    <= PCPOM_ZERO;
      oe_reg     <= PCPOM_ZERO;             // [RQ18]
      pb3_reg    <= 1'b0;
      pb3_oe_reg <= 1'b0;
      feed_reg   <= '0;
    end else begin
      latch_reg  <= latch_next;
      dir_reg    <= dir_next;
      periph_reg <= periph_next;
      sample_reg <= sample_next;
      rdata_reg  <= rdata_next;
      pin_reg    <= pin_next;
      oe_reg     <= oe_next;
      pb3_reg    <= pb3_next;
      pb3_oe_reg <= pb3_oe_next;
      feed_reg   <= feed_next;
    end
  end

  assign rdata_o               = rdata_reg;
  assign pin_o                 = pin_reg;
  assign pin_oe_o              = oe_reg;
  assign port_b_bit_three_o    = pb3_reg;
  assign port_b_bit_three_oe_o = pb3_oe_reg;
  assign feed_o                = feed_reg;

endmodule

// ---- dv/pcpom_mux_properties.sv ----
// checker for the port c pin override mux
// assumes one clock and the plain register port
`timescale 1ns/1ps
module pcpom_mux_properties (
  input wire logic                    clock_i,
  input wire logic                    sys_rst_i,
  input wire logic [1:0]              addr_i,
  input wire logic [7:0]              wdata_i,
  input wire logic                    wr_i,
  input wire logic                    rd_i,
  input wire logic [7:0]              rdata_o,
  input wire pcpom_pkg::pcpom_periph_t periph_i,
  input wire logic [7:0]              pin_i,
  input wire logic [7:0]              pin_o,
  input wire logic [7:0]              pin_oe_o
);
  import pcpom_pkg::*;
  // ---------------------------------------------------------------
  // register shadow
  // ---------------------------------------------------------------
  logic [7:0] dir_reg;
  logic [7:0] lat_reg;
  logic [7:0] en_reg;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dir_reg <= 8'hff;
      lat_reg <= 8'h00;
      en_reg  <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == 2'h2) dir_reg <= wdata_i;
      if (addr_i[1] == 1'b0) lat_reg <= wdata_i;
      if (addr_i == 2'h3) en_reg <= wdata_i;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_reset_inputs: assert property (
    $fell(sys_rst_i) |-> pin_oe_o == 8'h00) else $error("pins driven");
  chk_plain_pin: assert property (
    ##1 pin_oe_o[2] != $past(dir_reg[2])) else $error("bit two enable");
  chk_latch_read: assert property (
    rd_i && addr_i == 2'h1 |=> rdata_o == $past(lat_reg))
    else $error("latch read");
  chk_dir_read: assert property (
    rd_i && addr_i == 2'h2 |=> rdata_o == $past(dir_reg))
    else $error("direction read");
  chk_port_read: assert property (
    rd_i && addr_i == 2'h0 |=> rdata_o == $past(pin_i, 2))
    else $error("pin level read");
  chk_i2c_clk: assert property (
    en_reg[0] && periph_i.i2c_clk_oe |=> pin_oe_o[3]
    && pin_o[3] == $past(periph_i.i2c_clk_out)) else $error("i2c clock");
  chk_spi_out: assert property (
    en_reg[1] && !dir_reg[5] |=> pin_oe_o[5]
    && pin_o[5] == $past(periph_i.spi_data_out)) else $error("spi out");
  chk_tx_drive: assert property (
    en_reg[2] || en_reg[3] |=> pin_oe_o[6]) else $error("bit six drive");
  chk_slave_clk: assert property (
    en_reg[4] && !en_reg[2] && !en_reg[3] |=> !pin_oe_o[6])
    else $error("slave clock");
  chk_sync_tx: assert property (
    (en_reg[3] || en_reg[4]) && en_reg[5] |=> pin_oe_o[7]
    && pin_o[7] == $past(periph_i.xcvr_sync_data_out)) else $error("sync tx");
  cover property (en_reg[1] && !dir_reg[5]);
  cover property (rd_i && addr_i == 2'h0);
  cover property (en_reg[4]);
  cover property (en_reg[3] && en_reg[5]);
endmodule
bind pcpom_mux pcpom_mux_properties chk (.clock_i, .sys_rst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .periph_i, .pin_i, .pin_o, .pin_oe_o);

// ---- dv/pcpom_pin_model.sv ----
// pad model: resolves each port c pad from device and far side
// assumes the far side drives ext_d_i where ext_oe_i is set
`timescale 1ns/1ps
module pcpom_pin_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] dev_d_i,
  input  wire logic [7:0] dev_oe_i,
  input  wire logic [7:0] ext_d_i,
  input  wire logic [7:0] ext_oe_i,
  output logic      [7:0] pad_o
);
  // no pull on these pads, so a floating level wanders every cycle
  logic [7:0] float_reg = 8'h5a;
  always_ff @(posedge clock_i) float_reg <= ~float_reg;
  always_comb pad_o = (dev_oe_i & dev_d_i)
    | (~dev_oe_i & ext_oe_i & ext_d_i) | (~dev_oe_i & ~ext_oe_i & float_reg);
endmodule

// ---- dv/port_c_upper_pin_override_mux_bench.sv ----
// self-checking bench for the port c pin override mux
// assumes the pad model and the bound checker
`timescale 1ns/1ps
module port_c_upper_pin_override_mux_bench;
  import pcpom_pkg::*;
  logic          clock_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          wr_i = 1'b0;
  logic          rd_i = 1'b0;
  logic          sel = 1'b1;
  logic          pb_o;
  logic          pb_oe;
  logic [1:0]    addr_i = 2'h0;
  logic [7:0]    wdata_i = 8'h00;
  logic [7:0]    ext_d = 8'h00;
  logic [7:0]    rdata_o, pin_i, pin_o, pin_oe_o, dir, lat;
  pcpom_periph_t periph_i = 10'h000;
  pcpom_feed_t   feed_o;
  int            error_cnt = 0;
  int            checks = 0;
  pcpom_mux dut (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .capture_unit_pin_select_i(sel), .periph_i, .feed_o, .pin_i,
    .pin_o, .pin_oe_o, .port_b_bit_three_i(pin_i[3]),
    .port_b_bit_three_o(pb_o), .port_b_bit_three_oe_o(pb_oe));
  pcpom_pin_model far (.clock_i, .dev_d_i(pin_o), .dev_oe_i(pin_oe_o),
    .ext_d_i(ext_d), .ext_oe_i(8'hff), .pad_o(pin_i));
  initial forever #4 clock_i = ~clock_i;
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    test_done();
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // pad level with no peripheral claiming a pin
  function automatic logic [7:0] pad(input logic [7:0] d, l, x);
    return (~d & l) | (d & x);
  endfunction
  initial begin
    dir = $urandom(18);
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1 chk(pin_oe_o, 8'h00);
    rd(2'h2, 8'hff);
    rd(2'h1, 8'h00);
    repeat (40) begin
      dir = $urandom();
      lat = $urandom();
      ext_d = $urandom();
      wr({1'b0, lat[0]}, lat);
      wr(2'h2, dir);
      repeat (2) @(posedge clock_i);
      #1 chk(pin_oe_o, ~dir);
      chk(pin_i, pad(dir, lat, ext_d));
      rd(2'h0, pad(dir, lat, ext_d));
      rd(2'h1, lat);
      rd(2'h2, dir);
      chk({7'h00, feed_o.spi_data_in}, {7'h00, pin_i[4]});
      chk({feed_o.i2c_clk_in, feed_o.i2c_data_in, feed_o.xcvr_rx_data,
           feed_o.xcvr_sync_clk_in, feed_o.xcvr_sync_data_in,
           feed_o.capture_in, 2'h0},
          {pin_i[3], pin_i[4], pin_i[7], pin_i[6], pin_i[7], pin_i[1],
           2'h0});
    end
    wr(2'h2, 8'h00);
    for (int m = 0; m < 7; m++) begin
      wr(2'h3, 8'h01 << m);
      repeat (8) begin
        @(posedge clock_i);
        periph_i <= pcpom_periph_t'(10'($urandom()));
        sel <= 1'($urandom());
      end
    end
    #1 chk({7'h00, feed_o.smbus_levels}, 8'h01);
    // sync master transmitting: clock on bit six, data on bit seven
    wr(2'h3, 8'h28);
    periph_i <= 10'h001;
    repeat (3) @(posedge clock_i);
    #1 chk({4'h0, pin_oe_o[7:6], pin_o[7:6]}, 8'h0e);
    // capture out and enable, routed to the alternate pin
    @(posedge clock_i);
    sel <= 1'b0;
    periph_i <= 10'h018;
    repeat (3) @(posedge clock_i);
    #1 chk({6'h00, pb_oe, pb_o}, 8'h03);
    test_done();
  end
endmodule
